// file: verilog/snvcp_pkg.sv
// Constants and types shared by the serial nonvolatile RAM command port.
package snvcp_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_NS        = 4;
   localparam int STORE_NS      = 5000000;
   localparam int RECALL_NS     = 2000;
   localparam int STORE_CYCLES  = STORE_NS / CLK_NS;
   localparam int RECALL_CYCLES = RECALL_NS / CLK_NS;
   localparam int NV_CNT_W      = 21;

   // ----------------------------------------------------------------------
   // Array and instruction geometry
   // ----------------------------------------------------------------------
   localparam int WORD_W   = 16;
   localparam int WORDS    = 16;
   localparam int ADDR_W   = 4;
   localparam int INSTR_W  = 8;
   localparam int BITCNT_W = 5;
   localparam logic [BITCNT_W-1:0] CNT_ADDR_DONE  = 5'h06;
   localparam logic [BITCNT_W-1:0] CNT_INSTR_DONE = 5'h07;
   localparam logic [BITCNT_W-1:0] CNT_RD_ARMED   = 5'h08;
   localparam logic [BITCNT_W-1:0] CNT_SAT        = 5'h1f;
   localparam logic [INSTR_W-1:0]  INSTR_START    = 8'h01;

   // Operation codes in bits 2..0 of the instruction.
   localparam logic [2:0] OP_WRITE_LOCK   = 3'h0;
   localparam logic [2:0] OP_COMMIT       = 3'h1;
   localparam logic [2:0] OP_RESERVED     = 3'h2;
   localparam logic [2:0] OP_WRITE        = 3'h3;
   localparam logic [2:0] OP_WRITE_UNLOCK = 3'h4;
   localparam logic [2:0] OP_RELOAD       = 3'h5;
   localparam logic [1:0] OP_READ_HI      = 2'h3;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_STATUS   = 8'h00;
   localparam logic [7:0] REG_EE_INDEX = 8'h04;
   localparam logic [7:0] REG_EE_WORD  = 8'h08;
   localparam logic [7:0] REG_RAM_WORD = 8'h0c;
   localparam int ST_WEL      = 0;
   localparam int ST_PREV_RCL = 1;
   localparam int ST_STORING  = 2;
   localparam int ST_RECALLING= 3;
   localparam int ST_SELECTED = 4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      SER_IDLE  = 5'b00001,
      SER_INSTR = 5'b00010,
      SER_RDATA = 5'b00100,
      SER_WDATA = 5'b01000,
      SER_HOLD  = 5'b10000
   } snvcp_ser_t;

   typedef enum logic [2:0] {
      NV_IDLE   = 3'b001,
      NV_RECALL = 3'b010,
      NV_STORE  = 3'b100
   } snvcp_nv_t;

endpackage

// file: verilog/snvcp_top.sv
// Serial command port, RAM and EEPROM shadow, store/recall engine, AXI4-Lite view.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Eight-bit instruction register shifts serial_in on each shift_clock rising edge.
// - Instruction MSB first; bit7 one, bits6-3 address, bits2-0 operation.
// - Input ignored after selection until first one bit starts an instruction.
// - Select low means standby and cleared instruction register.
// - Shifting is static; clock pauses freeze position, resume continues.
// - Serial output enabled only while returning read data.
// - Reload command or low recall pin copies EEPROM to RAM, sets recall latch.
// - Recall latch clear at reset; power-up recall leaves it clear.
// - Write-enable latch set by unlock, cleared by lock; blocks serial writes and stores.
// - Store starts on commit or store pin only with both latches set.
// - Store inhibits serial commands, recall and EEPROM word writes, and clears write-enable latch when done.
// - Store completes within five milliseconds, recall within two microseconds.
// - Write carries four-bit address followed by sixteen data bits.
// - Early deselect during write still writes the bits received.
// - Beyond twenty-four clocks, write bits keep shifting and overwrite.
// - Read ignores lowest instruction bit; data valid during ninth clock.
// - First read bit on eighth falling edge, later bits on rising edges.
// - Legacy power-saving instruction accepted and ignored.
// - Sixteen words of sixteen bits, each RAM bit paired with EEPROM bit.
// - Commands ignored during the power-up recall.
module snvcp_top #(
   parameter int STORE_CYCLES = snvcp_pkg::STORE_CYCLES
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Serial command pins
   input  wire logic        select,
   input  wire logic        shift_clock,
   input  wire logic        serial_in,
   output logic             serial_out,
   output logic             serial_out_oe,
   // Hardware transfer pins
   input  wire logic        store_n,
   input  wire logic        recall_n,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic       sk_prev_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q  <= 5'h18;
         pin_s2_q  <= 5'h18;
         sk_prev_q <= 1'b0;
      end else begin
         pin_s1_q  <= {store_n, recall_n, select, shift_clock, serial_in};
         pin_s2_q  <= pin_s1_q;
         sk_prev_q <= pin_s2_q[1];
      end
   end

   wire si_s      = pin_s2_q[0];
   wire sk_s      = pin_s2_q[1];
   wire sel_s     = pin_s2_q[2];
   wire recall_lo = ~pin_s2_q[3];
   wire store_lo  = ~pin_s2_q[4];
   // Edges exist only when the host moves the clock, so a stopped clock freezes all shifting.
   wire sk_rise   = sk_s & ~sk_prev_q;
   wire sk_fall   = ~sk_s & sk_prev_q;

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [snvcp_pkg::WORD_W-1:0] ram_q [snvcp_pkg::WORDS];
   logic [snvcp_pkg::WORD_W-1:0] ee_q  [snvcp_pkg::WORDS];

   // ----------------------------------------------------------------------
   // Serial decoder
   // ----------------------------------------------------------------------
   snvcp_pkg::snvcp_ser_t                ser_q;
   logic [snvcp_pkg::INSTR_W-1:0]        instr_q;
   logic [snvcp_pkg::BITCNT_W-1:0]       cnt_q;
   logic [snvcp_pkg::ADDR_W-1:0]         addr_q;
   logic [snvcp_pkg::WORD_W-1:0]         sh_q;
   logic                                 so_q;
   logic                                 so_oe_q;
   snvcp_pkg::snvcp_nv_t                 nv_q;
   logic                                 wel_q;
   logic                                 prev_q;

   wire       nv_busy    = (nv_q != snvcp_pkg::NV_IDLE);
   wire       ser_clear  = ~sel_s | nv_busy;
   wire [2:0] op_full    = {instr_q[1:0], si_s};
   wire       op_read    = ({instr_q[0], si_s} == snvcp_pkg::OP_READ_HI);
   wire       instr_done = (ser_q == snvcp_pkg::SER_INSTR) && sk_rise && !ser_clear
                           && (cnt_q == snvcp_pkg::CNT_INSTR_DONE);
   wire       cmd_lock   = instr_done && (op_full == snvcp_pkg::OP_WRITE_LOCK);
   wire       cmd_unlock = instr_done && (op_full == snvcp_pkg::OP_WRITE_UNLOCK);
   wire       cmd_commit = instr_done && (op_full == snvcp_pkg::OP_COMMIT);
   wire       cmd_reload = instr_done && (op_full == snvcp_pkg::OP_RELOAD);
   wire       cmd_write  = instr_done && (op_full == snvcp_pkg::OP_WRITE);
   // A deselect with at least one data bit shifted commits the word, whole or partial.
   wire       ser_wr     = (ser_q == snvcp_pkg::SER_WDATA) && !sel_s && !nv_busy
                           && (cnt_q != 5'h00) && wel_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ser_q   <= snvcp_pkg::SER_IDLE;
         instr_q <= '0;
         cnt_q   <= '0;
         addr_q  <= '0;
         sh_q    <= '0;
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (ser_clear) begin
         ser_q   <= snvcp_pkg::SER_IDLE;
         instr_q <= '0;
         cnt_q   <= '0;
         so_oe_q <= 1'b0;
      end else begin
         case (ser_q)
            snvcp_pkg::SER_IDLE: begin
               if (sk_rise && si_s) begin
                  instr_q <= snvcp_pkg::INSTR_START;
                  cnt_q   <= 5'h01;
                  ser_q   <= snvcp_pkg::SER_INSTR;
               end
            end
            snvcp_pkg::SER_INSTR: begin
               if (sk_rise) begin
                  instr_q <= {instr_q[6:0], si_s};
                  cnt_q   <= cnt_q + 5'h01;
                  if (cnt_q == snvcp_pkg::CNT_ADDR_DONE && op_read) begin
                     addr_q <= instr_q[4:1];
                     ser_q  <= snvcp_pkg::SER_RDATA;
                  end else if (cnt_q == snvcp_pkg::CNT_INSTR_DONE) begin
                     addr_q <= instr_q[5:2];
                     cnt_q  <= 5'h00;
                     if (cmd_write) begin
                        sh_q  <= ram_q[instr_q[5:2]];
                        ser_q <= snvcp_pkg::SER_WDATA;
                     end else begin
                        // Reserved and legacy codes land here and do nothing.
                        ser_q <= snvcp_pkg::SER_HOLD;
                     end
                  end
               end
            end
            snvcp_pkg::SER_RDATA: begin
               if (cnt_q == snvcp_pkg::CNT_INSTR_DONE) begin
                  if (sk_rise) begin
                     cnt_q <= snvcp_pkg::CNT_RD_ARMED;
                  end
               end else if (cnt_q == snvcp_pkg::CNT_RD_ARMED) begin
                  if (sk_fall) begin
                     sh_q    <= ram_q[addr_q];
                     so_q    <= ram_q[addr_q][15];
                     so_oe_q <= 1'b1;
                     cnt_q   <= snvcp_pkg::CNT_SAT;
                  end
               end else if (sk_rise) begin
                  // The word recirculates, so a long read repeats it.
                  sh_q <= {sh_q[14:0], sh_q[15]};
                  so_q <= sh_q[14];
               end
            end
            snvcp_pkg::SER_WDATA: begin
               if (sk_rise) begin
                  sh_q <= {sh_q[14:0], si_s};
                  if (cnt_q != snvcp_pkg::CNT_SAT) begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
            end
            snvcp_pkg::SER_HOLD: begin
               ser_q <= snvcp_pkg::SER_HOLD;
            end
            default: begin
               ser_q <= snvcp_pkg::SER_IDLE;
            end
         endcase
      end
   end

   assign serial_out    = so_q;
   assign serial_out_oe = so_oe_q;

   // ----------------------------------------------------------------------
   // Store and recall engine
   // ----------------------------------------------------------------------
   logic [snvcp_pkg::NV_CNT_W-1:0] nv_cnt_q;

   wire req_recall  = cmd_reload | recall_lo;
   wire req_store   = (cmd_commit | store_lo) & wel_q & prev_q;
   wire recall_done = (nv_q == snvcp_pkg::NV_RECALL)
                      && (nv_cnt_q == 21'(snvcp_pkg::RECALL_CYCLES - 1));
   wire store_done  = (nv_q == snvcp_pkg::NV_STORE)
                      && (nv_cnt_q == 21'(STORE_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Leaving reset runs the automatic recall without touching the latch.
         nv_q     <= snvcp_pkg::NV_RECALL;
         nv_cnt_q <= '0;
         prev_q   <= 1'b0;
      end else begin
         case (nv_q)
            snvcp_pkg::NV_IDLE: begin
               nv_cnt_q <= '0;
               if (req_recall) begin
                  nv_q   <= snvcp_pkg::NV_RECALL;
                  prev_q <= 1'b1;
               end else if (req_store) begin
                  nv_q   <= snvcp_pkg::NV_STORE;
               end
            end
            snvcp_pkg::NV_RECALL: begin
               nv_cnt_q <= nv_cnt_q + 21'h000001;
               if (recall_done) begin
                  nv_q <= snvcp_pkg::NV_IDLE;
               end
            end
            snvcp_pkg::NV_STORE: begin
               nv_cnt_q <= nv_cnt_q + 21'h000001;
               if (store_done) begin
                  nv_q <= snvcp_pkg::NV_IDLE;
               end
            end
            default: begin
               nv_q <= snvcp_pkg::NV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wel_q <= 1'b0;
      end else if (store_done) begin
         wel_q <= 1'b0;
      end else if (cmd_unlock) begin
         wel_q <= 1'b1;
      end else if (cmd_lock) begin
         wel_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   logic                  aw_hold_q;
   logic                  w_hold_q;
   logic [7:0]            awaddr_q;
   logic [31:0]           wdata_q;
   logic [3:0]            wstrb_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [1:0]            rresp_q;
   logic [31:0]           rdata_q;
   logic [snvcp_pkg::ADDR_W-1:0] ee_idx_q;

   wire wr_go     = aw_hold_q && w_hold_q && !bvalid_q;
   wire wr_idx    = wr_go && (awaddr_q == snvcp_pkg::REG_EE_INDEX);
   wire wr_ee     = wr_go && (awaddr_q == snvcp_pkg::REG_EE_WORD) && !nv_busy;
   wire wr_mapped = (awaddr_q == snvcp_pkg::REG_STATUS) || (awaddr_q == snvcp_pkg::REG_EE_INDEX)
                    || (awaddr_q == snvcp_pkg::REG_EE_WORD)
                    || (awaddr_q == snvcp_pkg::REG_RAM_WORD);
   wire rd_go     = s_axi_arvalid && !rvalid_q;
   wire [31:0] status_w = {27'h0, sel_s, nv_q == snvcp_pkg::NV_RECALL,
                           nv_q == snvcp_pkg::NV_STORE, prev_q, wel_q};
   wire [31:0] ee_word_w  = {16'h0, ee_q[ee_idx_q]};
   wire [31:0] ram_word_w = {16'h0, ram_q[ee_idx_q]};
   wire [31:0] ee_new_w   = byte_merge(ee_word_w, wdata_q, wstrb_q);
   wire [31:0] idx_new_w  = byte_merge({28'h0, ee_idx_q}, wdata_q, wstrb_q);
   wire        rd_hit_st  = (s_axi_araddr == snvcp_pkg::REG_STATUS);
   wire        rd_hit_ix  = (s_axi_araddr == snvcp_pkg::REG_EE_INDEX);
   wire        rd_hit_ee  = (s_axi_araddr == snvcp_pkg::REG_EE_WORD);
   wire        rd_hit_rm  = (s_axi_araddr == snvcp_pkg::REG_RAM_WORD);
   wire [31:0] rd_mux     = rd_hit_st ? status_w :
                            rd_hit_ix ? {28'h0, ee_idx_q} :
                            rd_hit_ee ? ee_word_w :
                            rd_hit_rm ? ram_word_w : snvcp_pkg::RST_WORD;
   wire        rd_mapped  = rd_hit_st | rd_hit_ix | rd_hit_ee | rd_hit_rm;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= snvcp_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'h0};
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? snvcp_pkg::RESP_OKAY : snvcp_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= snvcp_pkg::RESP_OKAY;
         rdata_q  <= snvcp_pkg::RST_WORD;
         ee_idx_q <= '0;
      end else begin
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_mapped ? snvcp_pkg::RESP_OKAY : snvcp_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
         if (wr_idx) begin
            ee_idx_q <= idx_new_w[3:0];
         end
      end
   end

   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready  = !w_hold_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // ----------------------------------------------------------------------
   // Array updates
   // ----------------------------------------------------------------------
   // The arrays carry data, not control, so they keep no reset value.
   always_ff @(posedge aclk) begin
      if (recall_done) begin
         for (int i = 0; i < snvcp_pkg::WORDS; i++) begin
            ram_q[i] <= ee_q[i];
         end
      end else if (ser_wr) begin
         ram_q[addr_q] <= sh_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (store_done) begin
         for (int i = 0; i < snvcp_pkg::WORDS; i++) begin
            ee_q[i] <= ram_q[i];
         end
      end else if (wr_ee) begin
         ee_q[ee_idx_q] <= ee_new_w[15:0];
      end
   end

endmodule

`default_nettype wire

// file: testbench/snvcp_chk.sv
// Concurrent checks on the serial pins and register bus handshakes of the command port.
`timescale 1ns/1ps
`default_nettype none
module snvcp_chk (
   // Clock, reset and serial pins
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        select,
   input wire logic        shift_clock,
   input wire logic        serial_out,
   input wire logic        serial_out_oe,
   // Register bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // The pins pass a synchroniser, so the output may lag the pin by a few cycles.
   oe_desel_a: assert property (!select [*8] |-> !serial_out_oe)
      else $error("serial output enabled while deselected");
   oe_rise_a: assert property ($rose(serial_out_oe) |-> select && $past(select, 4))
      else $error("serial output enabled outside a selected read");
   out_static_a: assert property ((serial_out_oe && $stable(shift_clock)) [*6] |-> $stable(serial_out))
      else $error("serial output moved without a shift clock edge");
   b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   oe_on_fall_a: assert property ($rose(serial_out_oe) |-> !shift_clock)
      else $error("serial output enabled away from a low shift clock");
endmodule
bind snvcp_top snvcp_chk u_chk (.*);
`default_nettype wire

// file: testbench/snvcp_host.sv
// Host controller model that drives the serial command pins in frames.
`timescale 1ns/1ps
`default_nettype none
module snvcp_host (
   // Bench clock
   input wire logic  aclk,
   // Serial pins
   output logic      select,
   output logic      shift_clock,
   output logic      serial_in,
   input wire logic  serial_out
);
   initial begin
      select = 1'b0;
      shift_clock = 1'b0;
      serial_in = 1'b0;
   end
   // Sends n bits of v MSB first; the clock may stall before bit number pause.
   task automatic frame(input logic [47:0] v, input int n, input int pause,
                        output logic [15:0] rd);
      // A quarter nanosecond past an edge keeps every pin change off the sampling edges.
      @(posedge aclk);
      #0.25;
      select = 1'b1;
      #300;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = v[i];
         #62.5;
         rd = {rd[14:0], serial_out};
         if (i == pause) #2000;
         shift_clock = 1'b1;
         #62.5;
         shift_clock = 1'b0;
      end
      #100;
      select = 1'b0;
      // A released data line must not keep looking valid.
      serial_in = ~serial_in;
      #300;
   endtask
endmodule
`default_nettype wire

// file: testbench/test_snvcp_top.sv
// Self-checking bench of the serial nonvolatile RAM command port.
`timescale 1ns/1ps
`default_nettype none
module test_snvcp_top;
   logic        aclk = 1'b0, aresetn = 1'b0, store_n = 1'b1, recall_n = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] d;
   logic [15:0] rd;
   wire         select, shift_clock, serial_in, serial_out, serial_out_oe;
   int          mismatches = 0, num_checks = 0, cyc = 0;

   snvcp_top #(.STORE_CYCLES(2000)) dut (.*);
   // A released output shows the inverse of its last bit, so a late enable cannot pass.
   snvcp_host host (.aclk(aclk), .select(select), .shift_clock(shift_clock),
                    .serial_in(serial_in), .serial_out(serial_out_oe ? serial_out : ~serial_out));

   initial begin
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   // Polls until neither store nor recall is running.
   task automatic idle();
      repeat (3) @(posedge aclk);
      do axr(8'h00, d, r); while (d[3:2] != 2'b00);
   endtask
   task automatic stchk(input logic [31:0] e);
      axr(8'h00, d, r);
      chk("latches", e, d & 32'h3);
   endtask
   task automatic ramchk(input logic [31:0] e);
      axr(8'h0c, d, r);
      chk("ram_word", e, d);
   endtask
   task automatic pin_low(input bit reload_cmd);
      int c0;
      @(posedge aclk);
      c0 = cyc;
      if (reload_cmd) recall_n <= 1'b0;
      else store_n <= 1'b0;
      repeat (10) @(posedge aclk);
      store_n <= 1'b1;
      recall_n <= 1'b1;
      idle();
      if (reload_cmd) chk("recall_cycles", 32'h1, {31'h0, (cyc - c0) <= snvcp_pkg::RECALL_CYCLES + 30});
   endtask

   task automatic t_reset();
      host.frame(48'h84, 8, -1, rd);
      idle();
      stchk(32'h0);
      axr(8'h40, d, r);
      chk("rd_unmapped", 32'h2, {30'h0, r});
      axw(8'h40, 32'h0, r);
      chk("wr_unmapped", 32'h2, {30'h0, r});
   endtask
   task automatic t_recall();
      axw(8'h04, 32'h3, r);
      axw(8'h08, 32'ha5c3, r);
      host.frame(48'h85, 12, -1, rd);
      idle();
      stchk(32'h2);
      host.frame(48'h9f0000, 24, -1, rd);
      chk("serial_read", 32'ha5c3, {16'h0, rd});
   endtask
   task automatic t_write();
      host.frame(48'h9b1234, 24, -1, rd);
      ramchk(32'ha5c3);
      host.frame(48'h84, 8, -1, rd);
      host.frame(48'h9b1234, 24, 10, rd);
      ramchk(32'h1234);
      host.frame(48'h9b56, 16, -1, rd);
      ramchk(32'h3456);
      host.frame(48'h9bdeadbeef, 40, -1, rd);
      ramchk(32'hbeef);
   endtask
   task automatic t_store();
      host.frame(48'h81, 8, -1, rd);
      // This write lands while the store still runs and must be dropped.
      host.frame(48'h9b1111, 24, -1, rd);
      idle();
      ramchk(32'hbeef);
      axr(8'h08, d, r);
      chk("ee_word", 32'hbeef, d);
      stchk(32'h2);
   endtask
   task automatic t_pins();
      axw(8'h08, 32'h0f0f, r);
      pin_low(1'b0);
      axr(8'h08, d, r);
      chk("ee_no_store", 32'h0f0f, d);
      pin_low(1'b1);
      ramchk(32'h0f0f);
   endtask
   task automatic t_latch();
      host.frame(48'h84, 8, -1, rd);
      stchk(32'h3);
      host.frame(48'hfa, 8, -1, rd);
      stchk(32'h3);
      host.frame(48'h80, 8, -1, rd);
      stchk(32'h2);
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_recall();
      t_write();
      t_store();
      t_pins();
      t_latch();
      wrap_up();
   end
endmodule
`default_nettype wire
